// ---- core/ch34_mode_config.sv ----
// ch34_mode_config: mode register for timer channels 3 and 4 behind an apb slave
// assumes apb on ref_clk; channel enables and trigger select held in a local control word
// Operation
// RULE_01: ch3 selection 00 at bits 1:0 makes channel 3 an output
// RULE_02: ch3 selection 01 captures own input, 10 captures channel 4 input
// RULE_03: ch3 selection 11 captures internal trigger, only with internal trigger source
// RULE_04: ch3 selection writable only while channel 3 is disabled
// RULE_05: ch4 selection 00 at bits 9:8 makes channel 4 an output
// RULE_06: ch4 selection 01 captures own input, 10 captures channel 3 input
// RULE_07: ch4 selection 11 captures internal trigger, only with internal trigger source
// RULE_08: ch4 selection writable only while channel 4 is disabled
// RULE_09: mode register at offset 0x1c, all fields reset to zero
// RULE_10: software keeps reserved bits 31:16 at zero
// RULE_11: ch4 output fields: clear 15, mode 14:12, preload 11, fast 10
// RULE_12: ch3 output fields: clear 7, mode 6:4, preload 3, fast 2
// RULE_13: in input mode ch3 bits 7:4 are filter, bits 3:2 prescaler
// RULE_14: prescaler 00,01,10,11 captures every 1,2,4,8 events
// RULE_15: a locked selection stays unchanged; other fields of that write still land
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module ch34_mode_config (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic timer_input_c,
	input wire logic timer_input_d,
	input wire logic internal_trigger_sig,
	output ccmode_pkg::ch_cfg_t ch3Cfg,
	output ccmode_pkg::ch_cfg_t ch4Cfg,
	output logic ch3_capture_in,
	output logic ch4_capture_in,
	output logic ch3CapturePulse,
	output logic ch4CapturePulse
);
	import ccmode_pkg::*;
	typedef struct packed {
		logic [31:0] mode;
		logic [31:0] ctrl;
		logic [31:0] rdata;
		logic ready;
		logic err;
		ch_cfg_t cfg3;
		ch_cfg_t cfg4;
		logic cap3;
		logic cap4;
		logic pulse3;
		logic pulse4;
		logic inC;
		logic inD;
		logic trg;
	} state_t;

	state_t s_d;
	state_t s_q;
	ch_cap_t cap3State;
	ch_cap_t cap4State;
	logic [31:0] wmask;
	logic [31:0] modeNew;
	logic setupPhase;
	logic accessPhase;
	logic known;
	logic ch3_channel_enable;
	logic ch4_channel_enable;
	logic [2:0] trigger_source_select;
	logic trigInternal;
	logic edgeC;
	logic edgeD;
	logic edgeT;

	// byte-lane mask from strobes, used on both writable registers
	function automatic logic [31:0] lane_mask(input logic [3:0] strb);
		lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
	endfunction

	// decode one channel's mode word into the carrier
	function automatic ch_cfg_t decode_ch(input logic [7:0] f);
		ch_cfg_t c;
		c.isOutput = (f[1:0] == SEL_OUTPUT);
		c.isInput = (f[1:0] != SEL_OUTPUT);
		c.clearEn = f[7] & c.isOutput;
		c.compareMode = c.isOutput ? f[6:4] : 3'h0;
		c.preloadEn = f[3] & c.isOutput;
		c.fastEn = f[2] & c.isOutput;
		c.inputFilter = c.isInput ? f[7:4] : 4'h0;
		c.capturePrescaler = c.isInput ? f[3:2] : 2'h0;
		decode_ch = c;
	endfunction

	assign ch3_channel_enable = s_q.ctrl[CTRL_CH3_EN_BIT];
	assign ch4_channel_enable = s_q.ctrl[CTRL_CH4_EN_BIT];
	assign trigger_source_select = s_q.ctrl[CTRL_TSEL_LSB +: 3];
	assign trigInternal = (trigger_source_select <= TSEL_INTERNAL_MAX);
	assign edgeC = timer_input_c & ~s_q.inC;
	assign edgeD = timer_input_d & ~s_q.inD;
	assign edgeT = internal_trigger_sig & ~s_q.trg;

	// channel 3 route: own input c, neighbour d
	capture_route u_route3 (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.dirSelect(s_q.mode[CH3_SEL_LSB +: 2]), // RULE_02 RULE_03
		.prescaler(s_q.mode[CH3_PSC_LSB +: 2]), // RULE_14
		.channelEnable(ch3_channel_enable),
		.trigInternal(trigInternal),
		.ownEdge(edgeC),
		.neighbourEdge(edgeD),
		.trigEdge(edgeT),
		.capState(cap3State)
	);

	// channel 4 route: own input d, neighbour c
	capture_route u_route4 (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.dirSelect(s_q.mode[CH4_SEL_LSB +: 2]), // RULE_06 RULE_07
		.prescaler(s_q.mode[CH4_PSC_LSB +: 2]), // RULE_14
		.channelEnable(ch4_channel_enable),
		.trigInternal(trigInternal),
		.ownEdge(edgeD),
		.neighbourEdge(edgeC),
		.trigEdge(edgeT),
		.capState(cap4State)
	);

	// apb slave, field locks and output registers
	always_comb begin
		s_d = s_q;
		setupPhase = psel & ~penable;
		accessPhase = psel & penable & s_q.ready;
		known = (paddr == MODE_CFG_OFFSET) || (paddr == CTRL_OFFSET) ||
			(paddr == STATUS_OFFSET);
		wmask = lane_mask(pstrb);
		modeNew = (s_q.mode & ~wmask) | (pwdata & wmask & MODE_CFG_RW_MASK);
		// selection fields hold while their channel runs; other fields still land
		if (ch3_channel_enable) begin
			modeNew[CH3_SEL_LSB +: 2] = s_q.mode[CH3_SEL_LSB +: 2]; // RULE_04 RULE_15
		end
		if (ch4_channel_enable) begin
			modeNew[CH4_SEL_LSB +: 2] = s_q.mode[CH4_SEL_LSB +: 2]; // RULE_08 RULE_15
		end
		// no wait state: ready rises in the first access cycle, transfer ends next edge
		s_d.ready = setupPhase;
		s_d.err = setupPhase & ~known;
		if (setupPhase && !pwrite) begin
			case (paddr)
				MODE_CFG_OFFSET: s_d.rdata = s_q.mode; // RULE_09
				CTRL_OFFSET: s_d.rdata = s_q.ctrl;
				STATUS_OFFSET: s_d.rdata = {24'h0, cap4State.captureValid,
					cap3State.captureValid, s_q.cfg4.isInput, s_q.cfg3.isInput,
					s_q.cap4, s_q.cap3, ch4_channel_enable, ch3_channel_enable};
				default: s_d.rdata = 32'h0;
			endcase
		end else if (accessPhase) begin
			s_d.rdata = 32'h0;
		end
		if (accessPhase && pwrite) begin
			if (paddr == MODE_CFG_OFFSET) begin
				s_d.mode = modeNew; // RULE_09 RULE_11 RULE_12
			end else if (paddr == CTRL_OFFSET) begin
				s_d.ctrl = (s_q.ctrl & ~wmask) | (pwdata & wmask & 32'h0000_0073);
			end
		end
		// registered channel views for the timer core
		s_d.cfg3 = decode_ch(s_q.mode[7:0]); // RULE_01 RULE_12 RULE_13
		s_d.cfg4 = decode_ch(s_q.mode[15:8]); // RULE_05 RULE_11
		s_d.cap3 = cap3State.captureIn;
		s_d.cap4 = cap4State.captureIn;
		s_d.pulse3 = cap3State.capturePulse;
		s_d.pulse4 = cap4State.capturePulse;
		s_d.inC = timer_input_c;
		s_d.inD = timer_input_d;
		s_d.trg = internal_trigger_sig;
	end

	// state register
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '0;
			s_q.mode <= MODE_CFG_RESET; // RULE_09
			s_q.ctrl <= CTRL_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata = s_q.rdata;
	assign pready = s_q.ready;
	assign pslverr = s_q.err;
	assign ch3Cfg = s_q.cfg3;
	assign ch4Cfg = s_q.cfg4;
	assign ch3_capture_in = s_q.cap3;
	assign ch4_capture_in = s_q.cap4;
	assign ch3CapturePulse = s_q.pulse3;
	assign ch4CapturePulse = s_q.pulse4;

	sequence s_wr_mode;
		psel && penable && pready && pwrite && paddr == MODE_CFG_OFFSET && pstrb[0];
	endsequence

	// routed edges pass two registers: the route state, then the output flop
	sequence s_cap3_late;
		##2 ch3_capture_in;
	endsequence

	sequence s_cap4_late;
		##2 ch4_capture_in;
	endsequence

	property p_ch3_out;
		@(posedge ref_clk) disable iff (!resetn)
		resetn && s_q.mode[1:0] == 2'b00 |=> ch3Cfg.isOutput; // views read zero in reset cycle
	endproperty
	a_ch3_out: assert property (p_ch3_out) else $error("ch3 not output"); // RULE_01

	property p_ch4_out;
		@(posedge ref_clk) disable iff (!resetn)
		resetn && s_q.mode[9:8] == 2'b00 |=> ch4Cfg.isOutput && !ch4Cfg.isInput;
	endproperty
	a_ch4_out: assert property (p_ch4_out) else $error("ch4 not output"); // RULE_05

	property p_ch3_own;
		@(posedge ref_clk) disable iff (!resetn)
		s_q.mode[1:0] == 2'b01 && edgeC |-> s_cap3_late;
	endproperty
	a_ch3_own: assert property (p_ch3_own) else $error("ch3 own input lost"); // RULE_02

	property p_ch4_nb;
		@(posedge ref_clk) disable iff (!resetn)
		s_q.mode[9:8] == 2'b10 && edgeC |-> s_cap4_late;
	endproperty
	a_ch4_nb: assert property (p_ch4_nb) else $error("ch4 neighbour lost"); // RULE_06

	property p_trig_gate;
		@(posedge ref_clk) disable iff (!resetn)
		s_q.mode[1:0] == 2'b11 && !trigInternal |-> ##2 !ch3_capture_in;
	endproperty
	a_trig_gate: assert property (p_trig_gate) else $error("trigger leaked"); // RULE_03

	property p_lock3;
		@(posedge ref_clk) disable iff (!resetn)
		s_wr_mode ##0 ch3_channel_enable |=> $stable(s_q.mode[1:0]);
	endproperty
	a_lock3: assert property (p_lock3) else $error("ch3 select changed"); // RULE_04

	property p_lock4;
		@(posedge ref_clk) disable iff (!resetn)
		s_wr_mode ##0 ch4_channel_enable |=> $stable(s_q.mode[9:8]);
	endproperty
	a_lock4: assert property (p_lock4) else $error("ch4 select changed"); // RULE_08

	property p_others;
		@(posedge ref_clk) disable iff (!resetn)
		s_wr_mode |=> s_q.mode[7:2] == $past(pwdata[7:2]);
	endproperty
	a_others: assert property (p_others) else $error("field lost"); // RULE_15

	property p_reserved;
		@(posedge ref_clk) disable iff (!resetn)
		1'b1 |-> s_q.mode[31:16] == 16'h0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits set"); // RULE_10

	property p_ch3_nb;
		@(posedge ref_clk) disable iff (!resetn)
		s_q.mode[1:0] == 2'b10 && edgeD |-> s_cap3_late;
	endproperty
	a_ch3_nb: assert property (p_ch3_nb) else $error("ch3 neighbour lost"); // RULE_02

	property p_ch3_trig;
		@(posedge ref_clk) disable iff (!resetn)
		s_q.mode[1:0] == 2'b11 && trigInternal && edgeT |-> s_cap3_late;
	endproperty
	a_ch3_trig: assert property (p_ch3_trig) else $error("ch3 trigger lost"); // RULE_03

	property p_ch4_own;
		@(posedge ref_clk) disable iff (!resetn)
		s_q.mode[9:8] == 2'b01 && edgeD |-> s_cap4_late;
	endproperty
	a_ch4_own: assert property (p_ch4_own) else $error("ch4 own input lost"); // RULE_06

	property p_ch4_trig;
		@(posedge ref_clk) disable iff (!resetn)
		s_q.mode[9:8] == 2'b11 && trigInternal && edgeT |-> s_cap4_late;
	endproperty
	a_ch4_trig: assert property (p_ch4_trig) else $error("ch4 trigger lost"); // RULE_07

	property p_ch4_gate;
		@(posedge ref_clk) disable iff (!resetn)
		s_q.mode[9:8] == 2'b11 && !trigInternal |-> ##2 !ch4_capture_in;
	endproperty
	a_ch4_gate: assert property (p_ch4_gate) else $error("ch4 trigger leaked"); // RULE_07

	// channel views lag the mode word by one register
	property p_ch3_ofields;
		@(posedge ref_clk) disable iff (!resetn)
		s_q.mode[1:0] == 2'b00 |=>
			{ch3Cfg.clearEn, ch3Cfg.compareMode, ch3Cfg.preloadEn, ch3Cfg.fastEn} ==
			$past(s_q.mode[7:2]);
	endproperty
	a_ch3_ofields: assert property (p_ch3_ofields) else $error("ch3 output fields"); // RULE_12

	property p_ch4_ofields;
		@(posedge ref_clk) disable iff (!resetn)
		s_q.mode[9:8] == 2'b00 |=>
			{ch4Cfg.clearEn, ch4Cfg.compareMode, ch4Cfg.preloadEn, ch4Cfg.fastEn} ==
			$past(s_q.mode[15:10]);
	endproperty
	a_ch4_ofields: assert property (p_ch4_ofields) else $error("ch4 output fields"); // RULE_11

	property p_ch3_ifields;
		@(posedge ref_clk) disable iff (!resetn)
		s_q.mode[1:0] != 2'b00 |=>
			{ch3Cfg.inputFilter, ch3Cfg.capturePrescaler} == $past(s_q.mode[7:2]);
	endproperty
	a_ch3_ifields: assert property (p_ch3_ifields) else $error("ch3 input fields"); // RULE_13

	property p_ch3_in_mode;
		@(posedge ref_clk) disable iff (!resetn)
		s_q.mode[1:0] != 2'b00 |=> ch3Cfg.isInput && !ch3Cfg.isOutput;
	endproperty
	a_ch3_in_mode: assert property (p_ch3_in_mode) else $error("ch3 not input"); // RULE_02

	property p_ch4_in_mode;
		@(posedge ref_clk) disable iff (!resetn)
		s_q.mode[9:8] != 2'b00 |=> ch4Cfg.isInput && !ch4Cfg.isOutput;
	endproperty
	a_ch4_in_mode: assert property (p_ch4_in_mode) else $error("ch4 not input"); // RULE_06

	// undivided capture: every routed edge of an enabled channel fires
	property p_ch3_psc1;
		@(posedge ref_clk) disable iff (!resetn)
		s_q.mode[3:0] == 4'b0001 && ch3_channel_enable && edgeC |-> ##2 ch3CapturePulse;
	endproperty
	a_ch3_psc1: assert property (p_ch3_psc1) else $error("ch3 capture missed"); // RULE_14

	property p_ch3_psc_off;
		@(posedge ref_clk) disable iff (!resetn)
		!ch3_channel_enable |-> ##2 !ch3CapturePulse;
	endproperty
	a_ch3_psc_off: assert property (p_ch3_psc_off) else $error("ch3 capture while off"); // RULE_14

	property p_ch4_psc_off;
		@(posedge ref_clk) disable iff (!resetn)
		!ch4_channel_enable |-> ##2 !ch4CapturePulse;
	endproperty
	a_ch4_psc_off: assert property (p_ch4_psc_off) else $error("ch4 capture while off"); // RULE_14
endmodule // ch34_mode_config
`default_nettype wire

// ---- inc/ccmode_pkg.sv ----
// ccmode_pkg: offsets, field positions, codes and carriers for the ch3/ch4 mode block
// assumes a 32-bit apb slave on a 10 MHz ref_clk
package ccmode_pkg;
	localparam logic [11:0] MODE_CFG_OFFSET = 12'h01c; // channel3_4_mode_config
	localparam logic [11:0] CTRL_OFFSET = 12'h020; // enables and trigger select
	localparam logic [11:0] STATUS_OFFSET = 12'h024; // routing and capture status
	localparam logic [31:0] MODE_CFG_RESET = 32'h0000_0000;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] MODE_CFG_RW_MASK = 32'h0000_ffff;
	localparam int CH3_SEL_LSB = 0;
	localparam int CH3_PSC_LSB = 2;
	localparam int CH3_FE_BIT = 2;
	localparam int CH3_PE_BIT = 3;
	localparam int CH3_MODE_LSB = 4;
	localparam int CH3_FILT_LSB = 4;
	localparam int CH3_CE_BIT = 7;
	localparam int CH4_SEL_LSB = 8;
	localparam int CH4_PSC_LSB = 10;
	localparam int CH4_FE_BIT = 10;
	localparam int CH4_PE_BIT = 11;
	localparam int CH4_MODE_LSB = 12;
	localparam int CH4_FILT_LSB = 12;
	localparam int CH4_CE_BIT = 15;
	localparam int CTRL_CH3_EN_BIT = 0;
	localparam int CTRL_CH4_EN_BIT = 1;
	localparam int CTRL_TSEL_LSB = 4;
	localparam logic [2:0] TSEL_INTERNAL_MAX = 3'h3; // codes 0..3 are internal triggers
	localparam logic [2:0] PSC_COUNT_RESET = 3'h0;

	// direction selection codes
	typedef enum logic [1:0] {
		SEL_OUTPUT = 2'b00,
		SEL_OWN_INPUT = 2'b01,
		SEL_NEIGHBOUR_INPUT = 2'b10,
		SEL_INTERNAL_TRIG = 2'b11
	} dir_sel_t;

	// per-channel configuration as seen by the timer core
	typedef struct packed {
		logic isOutput;
		logic isInput;
		logic clearEn;
		logic [2:0] compareMode;
		logic preloadEn;
		logic fastEn;
		logic [3:0] inputFilter;
		logic [1:0] capturePrescaler;
	} ch_cfg_t;

	// capture route and prescaler state per channel
	typedef struct packed {
		logic captureIn;
		logic captureValid;
		logic [2:0] pscCount;
		logic capturePulse;
	} ch_cap_t;

	// events a capture prescaler must see before firing
	function automatic logic [2:0] psc_limit(input logic [1:0] code);
		case (code)
			2'b00: psc_limit = 3'h0;
			2'b01: psc_limit = 3'h1;
			2'b10: psc_limit = 3'h3;
			default: psc_limit = 3'h7;
		endcase
	endfunction
endpackage

// ---- core/capture_route.sv ----
// capture_route: picks one channel's capture source and applies the capture prescaler
// assumes edges arrive as one-cycle pulses synchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none
module capture_route (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [1:0] dirSelect,
	input wire logic [1:0] prescaler,
	input wire logic channelEnable,
	input wire logic trigInternal,
	input wire logic ownEdge,
	input wire logic neighbourEdge,
	input wire logic trigEdge,
	output ccmode_pkg::ch_cap_t capState
);
	import ccmode_pkg::*;
	ch_cap_t s_d;
	ch_cap_t s_q;
	logic edgeSeen;

	// route the chosen source; trigger route only live with an internal trigger source
	always_comb begin
		s_d = s_q;
		edgeSeen = 1'b0;
		s_d.captureValid = 1'b1;
		case (dir_sel_t'(dirSelect))
			SEL_OUTPUT: s_d.captureValid = 1'b0;
			SEL_OWN_INPUT: edgeSeen = ownEdge;
			SEL_NEIGHBOUR_INPUT: edgeSeen = neighbourEdge;
			SEL_INTERNAL_TRIG: begin
				edgeSeen = trigEdge & trigInternal;
				s_d.captureValid = trigInternal;
			end
			default: s_d.captureValid = 1'b0;
		endcase
		s_d.captureIn = edgeSeen;
		s_d.capturePulse = 1'b0;
		// prescaler is cleared while the channel is off so counts restart cleanly
		if (!channelEnable || !s_d.captureValid) begin
			s_d.pscCount = PSC_COUNT_RESET;
		end else if (edgeSeen) begin
			if (s_q.pscCount >= psc_limit(prescaler)) begin
				s_d.pscCount = PSC_COUNT_RESET;
				s_d.capturePulse = 1'b1;
			end else begin
				s_d.pscCount = s_q.pscCount + 3'h1;
			end
		end
	end

	// state register
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign capState = s_q;
endmodule // capture_route
`default_nettype wire

// ---- bench/tb.sv ----
// tb: self-checking bench for ch34_mode_config over apb
// assumes ccmode_pkg compiled first; inputs driven by nonblocking writes at rising edges
`timescale 1ns/1ps
`default_nettype none
`define CHECK_EQ(nm, exp, got) checkCount++; if ((got) !== (exp)) begin numErrors++; \
	$display("ERROR %s expected %h seen %h", nm, exp, got); end
module tb;
	import ccmode_pkg::*;
	logic ref_clk, resetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdData;
	logic [3:0] pstrb;
	logic timer_input_c, timer_input_d, internal_trigger_sig;
	logic ch3_capture_in, ch4_capture_in, ch3CapturePulse, ch4CapturePulse;
	ch_cfg_t ch3Cfg, ch4Cfg, e3, e4;
	logic rdErr;
	int numErrors = 0;
	int checkCount = 0;
	int in3, in4, cap3, cap4;

	ch34_mode_config dut (.ref_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb, .prdata, .pready, .pslverr, .timer_input_c, .timer_input_d,
		.internal_trigger_sig, .ch3Cfg, .ch4Cfg, .ch3_capture_in, .ch4_capture_in,
		.ch3CapturePulse, .ch4CapturePulse);

	// 100 ns clock
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	// pulse counters; routed and prescaled events are one-cycle pulses
	always @(posedge ref_clk) begin
		if (ch3_capture_in === 1'b1) in3++;
		if (ch4_capture_in === 1'b1) in4++;
		if (ch3CapturePulse === 1'b1) cap3++;
		if (ch4CapturePulse === 1'b1) cap4++;
	end

	task automatic tallyAndFinish();
		$display("checks %0d errors %0d", checkCount, numErrors);
		if (numErrors == 0 && checkCount > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	// one apb transfer; the wait on pready is bounded
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			numErrors++;
			tallyAndFinish();
		end
		rdData = prdata;
		rdErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// upper bits kept zero by every caller
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d & MODE_CFG_RW_MASK);
	endtask

	task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		`CHECK_EQ("readback", exp, rdData)
	endtask

	// nc edges on input c, then nd on d, then nt on the trigger
	task automatic pulse(input int nc, input int nd, input int nt);
		in3 = 0;
		in4 = 0;
		cap3 = 0;
		cap4 = 0;
		for (int i = 0; i < nc + nd + nt; i++) begin
			@(posedge ref_clk);
			timer_input_c <= (i < nc);
			timer_input_d <= (i >= nc && i < nc + nd);
			internal_trigger_sig <= (i >= nc + nd);
			@(posedge ref_clk);
			timer_input_c <= 1'b0;
			timer_input_d <= 1'b0;
			internal_trigger_sig <= 1'b0;
		end
		repeat (6) @(posedge ref_clk);
	endtask

	task automatic scenOutputFields();
		wr(MODE_CFG_OFFSET, 32'h0000_b8d4);
		rdChk(MODE_CFG_OFFSET, 32'h0000_b8d4);
		e3 = '{isOutput:1, isInput:0, clearEn:1, compareMode:3'h5, preloadEn:0, fastEn:1,
			inputFilter:0, capturePrescaler:0};
		e4 = '{isOutput:1, isInput:0, clearEn:1, compareMode:3'h3, preloadEn:1, fastEn:0,
			inputFilter:0, capturePrescaler:0};
		`CHECK_EQ("ch3Cfg", e3, ch3Cfg)
		`CHECK_EQ("ch4Cfg", e4, ch4Cfg)
	endtask

	task automatic scenInputFields();
		wr(MODE_CFG_OFFSET, 32'h0000_66ad);
		rdChk(MODE_CFG_OFFSET, 32'h0000_66ad);
		e3 = '{isOutput:0, isInput:1, clearEn:0, compareMode:0, preloadEn:0, fastEn:0,
			inputFilter:4'ha, capturePrescaler:2'h3};
		e4 = '{isOutput:0, isInput:1, clearEn:0, compareMode:0, preloadEn:0, fastEn:0,
			inputFilter:4'h6, capturePrescaler:2'h1};
		`CHECK_EQ("ch3Cfg in", e3, ch3Cfg)
		`CHECK_EQ("ch4Cfg in", e4, ch4Cfg)
	endtask

	// c once, d twice, trigger three times; counts tell the sources apart
	task automatic scenRouting();
		for (int s = 1; s < 4; s++) begin
			wr(CTRL_OFFSET, 32'h0000_0000);
			wr(MODE_CFG_OFFSET, {16'h0000, 6'h00, s[1:0], 6'h00, s[1:0]});
			wr(CTRL_OFFSET, 32'h0000_0003);
			pulse(1, 2, 3);
			`CHECK_EQ("ch3 route", (s == 1) ? 1 : (s == 2) ? 2 : 3, cap3)
			`CHECK_EQ("ch4 route", (s == 1) ? 2 : (s == 2) ? 1 : 3, cap4)
			`CHECK_EQ("ch3 in", (s == 1) ? 1 : (s == 2) ? 2 : 3, in3)
			`CHECK_EQ("ch4 in", (s == 1) ? 2 : (s == 2) ? 1 : 3, in4)
		end
		wr(CTRL_OFFSET, 32'h0000_0043);
		pulse(0, 0, 3);
		`CHECK_EQ("ch3 ext trig", 0, cap3)
		`CHECK_EQ("ch4 ext trig", 0, cap4)
		rdChk(STATUS_OFFSET, 32'h0000_0033);
	endtask

	task automatic scenLock();
		wr(CTRL_OFFSET, 32'h0000_0000);
		wr(MODE_CFG_OFFSET, 32'h0000_0101);
		wr(CTRL_OFFSET, 32'h0000_0003);
		wr(MODE_CFG_OFFSET, 32'h0000_f2fe);
		rdChk(MODE_CFG_OFFSET, 32'h0000_f1fd);
		wr(CTRL_OFFSET, 32'h0000_0001);
		wr(MODE_CFG_OFFSET, 32'h0000_0202);
		rdChk(MODE_CFG_OFFSET, 32'h0000_0201);
	endtask

	task automatic scenPrescaler();
		for (int k = 0; k < 4; k++) begin
			wr(CTRL_OFFSET, 32'h0000_0000);
			wr(MODE_CFG_OFFSET, 32'h0000_0001 | (k << 2));
			wr(CTRL_OFFSET, 32'h0000_0001);
			pulse(8, 0, 0);
			`CHECK_EQ("psc count", 8 >> k, cap3)
		end
		// channel off: edges still routed, but no prescaled capture
		wr(CTRL_OFFSET, 32'h0000_0000);
		pulse(2, 0, 0);
		`CHECK_EQ("psc off", 0, cap3)
		`CHECK_EQ("off route", 2, in3)
	endtask

	// main sequence
	initial begin
		{psel, penable, pwrite, timer_input_c, timer_input_d, internal_trigger_sig} = '0;
		paddr = '0;
		pwdata = '0;
		pstrb = 4'hf;
		resetn = 1'b0;
		repeat (12) @(posedge ref_clk);
		resetn <= 1'b1;
		rdChk(MODE_CFG_OFFSET, MODE_CFG_RESET);
		`CHECK_EQ("ok err", 1'b0, rdErr)
		rdChk(CTRL_OFFSET, CTRL_RESET);
		rdChk(12'h040, 32'h0000_0000);
		`CHECK_EQ("unmapped err", 1'b1, rdErr)
		scenOutputFields();
		scenInputFields();
		scenRouting();
		scenLock();
		scenPrescaler();
		tallyAndFinish();
	end
endmodule // tb
`default_nettype wire
